// ---- clm_defines.svh ----
/*
 Offsets, field positions, reset values and codes of the custom logic unit.
 Assumes inclusion by bare name from the design modules.
*/
`ifndef CLM_DEFINES_SVH
`define CLM_DEFINES_SVH
// ----------------------------------------
// Register indexes, byte address is four times the index
// ----------------------------------------
`define CLM_IDX_GLOBAL 4'h0
`define CLM_IDX_SEQ 4'h1
`define CLM_IDX_TABLE_A 4'h5
`define CLM_IDX_TABLE_B 4'h6
`define CLM_IDX_TABLE_C 4'h7
`define CLM_IDX_TABLE_F 4'h8
`define CLM_TABLE_STRIDE 4'h4
`define CLM_RESET_BYTE 8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CLM_GC_ENABLE_BIT 0
`define CLM_GC_RUN_IN_STANDBY_BIT 6
`define CLM_CA_ENABLE_BIT 0
`define CLM_CA_PIN_OUTPUT_ENABLE_BIT 3
`define CLM_CA_FILT_LSB 4
`define CLM_CA_TABLE_CLOCK_SELECT_BIT 6
`define CLM_CA_EDGE_BIT 7
// ----------------------------------------
// Codes
// ----------------------------------------
`define CLM_SEQ_OFF 4'h0
`define CLM_SEQ_DFF 4'h1
`define CLM_SEQ_JK 4'h2
`define CLM_SEQ_DLATCH 4'h3
`define CLM_SEQ_RS 4'h4
`define CLM_FILT_NONE 2'h0
`define CLM_FILT_SYNC 2'h1
`define CLM_FILT_FULL 2'h2
`define CLM_SRC_MASK 4'h0
`define CLM_SRC_FEEDBACK 4'h1
`define CLM_SRC_LINK 4'h2
`define CLM_SRC_EVENT0 4'h3
`define CLM_SRC_EVENT1 4'h4
`define CLM_SRC_PIN 4'h5
`define CLM_SRC_CMP0 4'h6
`define CLM_SRC_TIMER_B0 4'h7
`define CLM_SRC_TIMER_A 4'h8
`define CLM_SRC_TIMER_D 4'h9
`define CLM_SRC_USART 4'ha
`define CLM_SRC_SPI 4'hb
`define CLM_SRC_CMP1 4'hc
`define CLM_SRC_TIMER_B1 4'hd
`define CLM_SRC_CMP2 4'he
`endif

// ---- clm_pkg.sv ----
/*
 Types shared by the custom logic unit modules.
 Assumes clm_defines.svh is on the include path.
*/
package clm_pkg;
	// ----------------------------------------
	// Source bundle
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] event_line;
		logic [1:0][2:0] pin;
		logic [2:0] comparator_output;
		logic [2:0] timer_a_output;
		logic [1:0] timer_b_output;
		logic timer_d_output_a;
		logic timer_d_output_b;
		logic usart_txd;
		logic usart_xck;
		logic spi_mosi;
		logic spi_sck;
		logic spi_miso;
	} clm_sources_t;
	typedef struct packed {
		logic edge_detect_enable;
		logic table_clock_select;
		logic [1:0] output_filter_select;
		logic pin_output_enable;
		logic enable;
	} clm_table_ctrl_t;
endpackage : clm_pkg

// ---- clm_table_stage.sv ----
/*
 Output filter and edge detector of one lookup table.
 Assumes tick is a one-cycle enable standing for an edge of the selected table clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "clm_defines.svh"
module clm_table_stage
(
	input wire logic clk,
	input wire logic reset,
	input wire logic clear,
	input wire logic tick,
	input wire logic [1:0] output_filter_select,
	input wire logic edge_detect_enable,
	input wire logic din,
	output logic dout
);
	logic [1:0] sync_q;
	logic [1:0] hist_q;
	logic filt_q;
	logic edge_prev_q;
	logic filtered;
	// ----------------------------------------
	// Selection
	// ----------------------------------------
	assign filtered = (output_filter_select == `CLM_FILT_SYNC) ? sync_q[1] :
		(output_filter_select == `CLM_FILT_FULL) ? filt_q : din;
	assign dout = edge_detect_enable ? (filtered & ~edge_prev_q) : filtered;
	// ----------------------------------------
	// Clocked state
	// ----------------------------------------
	// Clear acts one cycle after the table is disabled, the clock select notwithstanding.
	always_ff @(posedge clk)
	begin
		if (reset || clear)
		begin
			sync_q <= 2'h0;
			hist_q <= 2'h0;
			filt_q <= 1'b0;
			edge_prev_q <= 1'b0;
		end
		else if (tick)
		begin
			sync_q <= {sync_q[0], din};
			hist_q <= {hist_q[0], sync_q[1]};
			if (sync_q[1] == hist_q[0] && hist_q[0] == hist_q[1])
			begin
				filt_q <= sync_q[1];
			end
			edge_prev_q <= filtered;
		end
	end
endmodule : clm_table_stage
`default_nettype wire

// ---- clm_unit.sv ----
/*
 Custom logic unit: two lookup tables with input selectors, filters, edge detectors,
 one shared sequential element and a classic Wishbone register slave.
 Assumes all inputs are synchronous to clk and that sleep levels come from the power manager.
*/
`timescale 1ns/1ps
`default_nettype none
`include "clm_defines.svh"
// How it works
// - Run-in-standby set keeps the peripheral clock requested during Standby.
// - Otherwise Standby stops the clock; filtered, edged or sequenced outputs read 0.
// - Idle sleep keeps table evaluation and outputs running.
// - Clock select 1 lets input 2 edges clock filter, edge detector, sequencer.
// - Run-in-standby raises no clock request where no peripheral clock is needed.
// - Global bit 0 enables the unit; bit 6 holds run-in-standby.
// - Control A bit 0 enables its table.
// - Sequential codes: off, D flip-flop, JK flip-flop, D latch, RS latch.
// - Control A bit 7 switches the edge detector.
// - Control A bit 6 picks peripheral clock or input 2.
// - The shared sequencer follows the even table's clock.
// - Filter field: none, synchronizer only, full filter; 3 reserved.
// - Control A bit 3 drives the table output onto its pin.
// - Input 1 selector codes 0x0 to 0xE as listed.
// - Input 0 shares codes to 0x8; 0x9 inverted timer D A, 0xA USART clock.
// - Input 0 codes 0xB to 0xE: SPI clock, comparator 1, timer B1, comparator 2.
// - The function byte gives the output for each input combination.
// - Filtered output lags the plain result by two to five clocks.
module clm_unit
#(
	parameter int TABLES = 2
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic standby_sleep,
	input wire logic idle_sleep,
	input wire clm_pkg::clm_sources_t sources,
	output logic [TABLES-1:0] table_event,
	output logic [TABLES-1:0] table_output_pin_o,
	output logic [TABLES-1:0] table_output_pin_oe,
	output logic peripheral_clock_request
);
	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic pick_source(input logic [3:0] code, input logic [1:0] inp,
		input int tbl, input clm_pkg::clm_sources_t s, input logic fb, input logic lnk);
		logic r;
		r = 1'b0;
		case (code)
			`CLM_SRC_FEEDBACK: r = fb;
			`CLM_SRC_LINK: r = lnk;
			`CLM_SRC_EVENT0: r = s.event_line[0];
			`CLM_SRC_EVENT1: r = s.event_line[1];
			`CLM_SRC_PIN: r = s.pin[tbl][inp];
			`CLM_SRC_CMP0: r = s.comparator_output[0];
			`CLM_SRC_TIMER_B0: r = s.timer_b_output[0];
			`CLM_SRC_TIMER_A: r = s.timer_a_output[inp];
			`CLM_SRC_TIMER_D: r = (inp == 2'h0) ? ~s.timer_d_output_a :
				(inp == 2'h1) ? s.timer_d_output_b : s.timer_d_output_a;
			`CLM_SRC_USART: r = (inp == 2'h0) ? s.usart_xck :
				(inp == 2'h1) ? s.usart_txd : 1'b0;
			`CLM_SRC_SPI: r = (inp == 2'h0) ? s.spi_sck :
				(inp == 2'h1) ? s.spi_mosi : s.spi_miso;
			`CLM_SRC_CMP1: r = (inp == 2'h2) ? 1'b0 : s.comparator_output[1];
			`CLM_SRC_TIMER_B1: r = (inp == 2'h2) ? 1'b0 : s.timer_b_output[1];
			`CLM_SRC_CMP2: r = (inp == 2'h2) ? 1'b0 : s.comparator_output[2];
			default: r = 1'b0;
		endcase
		return r;
	endfunction : pick_source

	function automatic logic reg_hit(input logic [3:0] idx, input logic [3:0] where);
		return idx == where;
	endfunction : reg_hit

	function automatic logic seq_next(input logic [3:0] mode, input logic q,
		input logic a, input logic b, input logic tick);
		logic r;
		r = q;
		case (mode)
			`CLM_SEQ_DFF: r = (tick && b) ? a : q;
			`CLM_SEQ_JK:
			begin
				if (tick)
				begin
					r = ({a, b} == 2'b01) ? 1'b0 : ({a, b} == 2'b10) ? 1'b1 :
						({a, b} == 2'b11) ? ~q : q;
				end
			end
			`CLM_SEQ_DLATCH: r = b ? a : q;
			// Both inputs high is forbidden for the latch; holding keeps it predictable.
			`CLM_SEQ_RS: r = (a && !b) ? 1'b1 : (!a && b) ? 1'b0 : q;
			default: r = 1'b0;
		endcase
		return r;
	endfunction : seq_next
	// ----------------------------------------
	// Registers and bus decode
	// ----------------------------------------
	logic global_enable_q;
	logic run_in_standby_q;
	logic [3:0] sequential_select_q;
	clm_pkg::clm_table_ctrl_t ctrl_q [TABLES];
	logic [7:0] select_b_q [TABLES];
	logic [3:0] select_c_q [TABLES];
	logic [7:0] function_q [TABLES];
	logic ack_q;
	logic [31:0] rdata_q;
	logic [3:0] bus_idx;
	logic bus_req;
	logic bus_wr;
	logic prot_wr;
	logic [7:0] rd_byte;
	logic [7:0] rd_table [TABLES];
	logic [7:0] rd_tables_or;
	logic [7:0] wdat;

	assign bus_idx = wb_adr_i[5:2];
	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
	assign prot_wr = bus_wr & ~global_enable_q;
	assign wdat = wb_dat_i[7:0];

	always_comb
	begin
		rd_tables_or = 8'h00;
		for (int k = 0; k < TABLES; k++)
		begin
			rd_tables_or = rd_tables_or | rd_table[k];
		end
	end

	assign rd_byte = reg_hit(bus_idx, `CLM_IDX_GLOBAL) ?
		{1'b0, run_in_standby_q, 5'h00, global_enable_q} :
		reg_hit(bus_idx, `CLM_IDX_SEQ) ? {4'h0, sequential_select_q} : rd_tables_or;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			global_enable_q <= 1'b0;
			run_in_standby_q <= 1'b0;
			sequential_select_q <= `CLM_SEQ_OFF;
		end
		else
		begin
			ack_q <= bus_req;
			if (bus_req)
			begin
				rdata_q <= {24'h00_0000, rd_byte};
			end
			if (bus_wr && reg_hit(bus_idx, `CLM_IDX_GLOBAL))
			begin
				global_enable_q <= wdat[`CLM_GC_ENABLE_BIT];
				run_in_standby_q <= wdat[`CLM_GC_RUN_IN_STANDBY_BIT];
			end
			if (prot_wr && reg_hit(bus_idx, `CLM_IDX_SEQ))
			begin
				sequential_select_q <= wdat[3:0];
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;
	// ----------------------------------------
	// Clock availability
	// ----------------------------------------
	logic [TABLES-1:0] active;
	logic [TABLES-1:0] uses_clocked;
	logic [TABLES-1:0] needs_periph;
	logic clock_stopped;
	logic request_q;
	logic [TABLES-1:0] table_tick;
	logic [TABLES-1:0] staged;
	logic [TABLES-1:0] out_q;
	logic [TABLES-1:0] oe_q;
	logic seq_q;
	logic seq_out;
	logic seq_on;

	assign seq_on = (sequential_select_q != `CLM_SEQ_OFF);
	// Idle sleep leaves the clock alone, so idle_sleep needs no term here.
	assign clock_stopped = standby_sleep & ~(global_enable_q & run_in_standby_q);

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			request_q <= 1'b0;
		end
		else
		begin
			request_q <= global_enable_q & run_in_standby_q & (|needs_periph);
		end
	end

	assign peripheral_clock_request = request_q;
	// ----------------------------------------
	// Lookup tables
	// ----------------------------------------
	genvar t;
	generate
		for (t = 0; t < TABLES; t++)
		begin : g_table
			localparam logic [3:0] IDX_A = 4'(`CLM_IDX_TABLE_A + t * `CLM_TABLE_STRIDE);
			localparam logic [3:0] IDX_B = 4'(`CLM_IDX_TABLE_B + t * `CLM_TABLE_STRIDE);
			localparam logic [3:0] IDX_C = 4'(`CLM_IDX_TABLE_C + t * `CLM_TABLE_STRIDE);
			localparam logic [3:0] IDX_F = 4'(`CLM_IDX_TABLE_F + t * `CLM_TABLE_STRIDE);
			logic in0;
			logic in1;
			logic in2;
			logic in2_prev_q;
			logic in2_truth;
			logic lut_raw;
			logic result;
			logic link;
			logic seq_here;

			always_ff @(posedge clk)
			begin
				if (reset)
				begin
					ctrl_q[t] <= clm_pkg::clm_table_ctrl_t'(6'h00);
					select_b_q[t] <= `CLM_RESET_BYTE;
					select_c_q[t] <= 4'h0;
					function_q[t] <= `CLM_RESET_BYTE;
				end
				else if (prot_wr)
				begin
					if (reg_hit(bus_idx, IDX_A))
					begin
						ctrl_q[t].edge_detect_enable <= wdat[`CLM_CA_EDGE_BIT];
						ctrl_q[t].table_clock_select <= wdat[`CLM_CA_TABLE_CLOCK_SELECT_BIT];
						ctrl_q[t].output_filter_select <= wdat[`CLM_CA_FILT_LSB +: 2];
						ctrl_q[t].pin_output_enable <= wdat[`CLM_CA_PIN_OUTPUT_ENABLE_BIT];
						ctrl_q[t].enable <= wdat[`CLM_CA_ENABLE_BIT];
					end
					if (reg_hit(bus_idx, IDX_B))
					begin
						select_b_q[t] <= wdat;
					end
					if (reg_hit(bus_idx, IDX_C))
					begin
						select_c_q[t] <= wdat[3:0];
					end
					if (reg_hit(bus_idx, IDX_F))
					begin
						function_q[t] <= wdat;
					end
				end
			end

			assign rd_table[t] = reg_hit(bus_idx, IDX_A) ? {ctrl_q[t].edge_detect_enable,
				ctrl_q[t].table_clock_select, ctrl_q[t].output_filter_select,
				ctrl_q[t].pin_output_enable, 2'h0, ctrl_q[t].enable} :
				reg_hit(bus_idx, IDX_B) ? select_b_q[t] :
				reg_hit(bus_idx, IDX_C) ? {4'h0, select_c_q[t]} :
				reg_hit(bus_idx, IDX_F) ? function_q[t] : 8'h00;

			assign active[t] = global_enable_q & ctrl_q[t].enable;
			assign seq_here = (t % 2 == 0) && seq_on;
			assign uses_clocked[t] = (ctrl_q[t].output_filter_select != `CLM_FILT_NONE) |
				ctrl_q[t].edge_detect_enable | seq_here;
			assign needs_periph[t] = active[t] & uses_clocked[t] &
				~ctrl_q[t].table_clock_select;

			// The next table's output feeds the link, wrapping round at the last table.
			assign link = out_q[(t + 1) % TABLES];
			assign in0 = pick_source(select_b_q[t][3:0], 2'h0, t, sources, seq_q, link);
			assign in1 = pick_source(select_b_q[t][7:4], 2'h1, t, sources, seq_q, link);
			assign in2 = pick_source(select_c_q[t], 2'h2, t, sources, seq_q, link);
			assign in2_truth = in2 & ~ctrl_q[t].table_clock_select;
			assign lut_raw = function_q[t][{in2_truth, in1, in0}];

			always_ff @(posedge clk)
			begin
				if (reset)
				begin
					in2_prev_q <= 1'b0;
				end
				else
				begin
					in2_prev_q <= in2;
				end
			end

			// Input 2 edges go on in Standby; only the peripheral clock is stopped there.
			assign table_tick[t] = ctrl_q[t].table_clock_select ? (in2 & ~in2_prev_q) :
				~clock_stopped;

			clm_table_stage u_stage
			(
				.clk(clk),
				.reset(reset),
				.clear(~active[t]),
				.tick(table_tick[t]),
				.output_filter_select(ctrl_q[t].output_filter_select),
				.edge_detect_enable(ctrl_q[t].edge_detect_enable),
				.din(lut_raw),
				.dout(staged[t])
			);

			assign result = seq_here ? seq_out : staged[t];

			always_ff @(posedge clk)
			begin
				if (reset)
				begin
					out_q[t] <= 1'b0;
					oe_q[t] <= 1'b0;
				end
				else
				begin
					out_q[t] <= active[t] & ~(clock_stopped & uses_clocked[t]) & result;
					oe_q[t] <= active[t] & ctrl_q[t].pin_output_enable;
				end
			end
		end
	endgenerate
	// ----------------------------------------
	// Shared sequential element
	// ----------------------------------------
	// The latch modes are transparent in the same cycle, so the output is taken
	// from the next value rather than from the stored bit.
	assign seq_out = (sequential_select_q == `CLM_SEQ_DLATCH ||
		sequential_select_q == `CLM_SEQ_RS) ?
		seq_next(sequential_select_q, seq_q, staged[0], staged[TABLES-1], 1'b0) : seq_q;

	always_ff @(posedge clk)
	begin
		if (reset || !active[0])
		begin
			seq_q <= 1'b0;
		end
		else if (!clock_stopped || ctrl_q[0].table_clock_select)
		begin
			seq_q <= seq_next(sequential_select_q, seq_q, staged[0], staged[TABLES-1],
				table_tick[0]);
		end
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign table_event = out_q;
	assign table_output_pin_o = out_q;
	assign table_output_pin_oe = oe_q;
endmodule : clm_unit
`default_nettype wire

// ---- clm_unit_checker.sv ----
/*
 Assertions on the ports of the custom logic unit.
 Assumes a bind into clm_unit; control bits are shadowed from bus writes.
*/
`timescale 1ns/1ps
`default_nettype none
module clm_unit_checker
#(
	parameter int TABLES = 2
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic standby_sleep,
	input wire logic [TABLES-1:0] table_event,
	input wire logic [TABLES-1:0] table_output_pin_oe,
	input wire logic peripheral_clock_request
);
	// ----------------------------------------
	// Register shadow
	// ----------------------------------------
	logic take_wr;
	logic gen_q;
	logic rsb_q;
	logic [7:0] ca0_q;
	logic clocked0;
	assign take_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
	assign clocked0 = gen_q && ca0_q[0] && !ca0_q[6] && (ca0_q[5:4] inside {2'h1, 2'h2});
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			gen_q <= 1'b0;
			rsb_q <= 1'b0;
			ca0_q <= 8'h00;
		end
		else if (take_wr && wb_adr_i[5:2] == 4'h0)
		begin
			gen_q <= wb_dat_i[0];
			rsb_q <= wb_dat_i[6];
		end
		else if (take_wr && wb_adr_i[5:2] == 4'h5 && !gen_q)
		begin
			ca0_q <= wb_dat_i[7:0];
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("Request not answered in one cycle.");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("Ack longer than one cycle.");
	AST_GLOBAL_OFF: assert property (!$past(gen_q) |-> table_event == '0)
		else $error("Output while unit disabled.");
	AST_TABLE_OFF: assert property (!$past(ca0_q[0]) |-> !table_event[0])
		else $error("Output while table disabled.");
	AST_PIN_ENABLE: assert property (table_output_pin_oe[0] == $past(gen_q && ca0_q[0] && ca0_q[3]))
		else $error("Pin enable does not follow control.");
	AST_CLK_REQUEST: assert property ($past(clocked0 && rsb_q) |-> peripheral_clock_request)
		else $error("Clock request missing.");
	AST_CLK_CAUSE: assert property (peripheral_clock_request |-> $past(gen_q && rsb_q))
		else $error("Clock request without cause.");
	AST_STANDBY_ZERO: assert property ((standby_sleep && !rsb_q && clocked0) [*2] |-> !table_event[0])
		else $error("Filtered output not forced low in standby.");
	COV_STANDBY: cover property (standby_sleep && !rsb_q && clocked0 ##1 standby_sleep);
	COV_PIN: cover property (table_output_pin_oe[0] && table_event[0]);
	COV_REQUEST: cover property ($rose(peripheral_clock_request));
endmodule : clm_unit_checker
bind clm_unit clm_unit_checker #(.TABLES(TABLES)) u_checker
(
	.clk(clk),
	.reset(reset),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_ack_o(wb_ack_o),
	.standby_sleep(standby_sleep),
	.table_event(table_event),
	.table_output_pin_oe(table_output_pin_oe),
	.peripheral_clock_request(peripheral_clock_request)
);
`default_nettype wire

// ---- clm_src_model.sv ----
/*
 Peripherals, events and pins feeding the table inputs.
 Assumes levels from the bench; input 2 of table 0 can run as a clock.
*/
`timescale 1ns/1ps
`default_nettype none
module clm_src_model
(
	input wire logic clk,
	input wire logic reset,
	input wire clm_pkg::clm_sources_t levels,
	input wire logic in2_run,
	output var clm_pkg::clm_sources_t sources
);
	logic in2_q;
	clm_pkg::clm_sources_t lv_q;
	// Serial lines change like a master's, the only mode the tables can use.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			lv_q <= '0;
			in2_q <= 1'b0;
		end
		else
		begin
			lv_q <= levels;
			in2_q <= in2_run && !in2_q;
		end
	end
	// The input 2 clock stands still low between bursts.
	always_comb
	begin
		sources = lv_q;
		sources.pin[0][2] = lv_q.pin[0][2] | in2_q;
	end
endmodule : clm_src_model
`default_nettype wire

// ---- tb.sv ----
/*
 Self-checking bench for the custom logic unit over classic Wishbone.
 Assumes clm_src_model as the source side.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [5:0] wb_adr = 6'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_wdat = 32'h0;
	logic [31:0] wb_rdat;
	logic wb_ack;
	logic standby = 1'b0;
	logic idle = 1'b0;
	logic run2 = 1'b0;
	clm_pkg::clm_sources_t levels = '0;
	clm_pkg::clm_sources_t sources;
	logic [1:0] tev;
	logic [1:0] pin_o;
	logic [1:0] pin_oe;
	logic clk_req;
	logic [3:0] code;
	logic in1;
	logic inv;
	int n;
	int err_total = 0;
	int n_tests = 0;
	int lo [3] = '{3, 5, 7};
	int hi [3] = '{3, 5, 8};
	logic [5:0] adrs [12] = '{6'h00, 6'h04, 6'h14, 6'h18, 6'h1c, 6'h20,
		6'h24, 6'h28, 6'h2c, 6'h30, 6'h08, 6'h3c};
	logic [7:0] wv [12] = '{8'h41, 8'h04, 8'he9, 8'hee, 8'h05, 8'ha5,
		8'h99, 8'h5a, 8'h0b, 8'h3c, 8'hff, 8'hff};
	logic [7:0] sq [4] = '{8'h01, 8'h02, 8'h03, 8'h04};
	always #12.5 clk = ~clk;
	clm_unit DUT
	(
		.clk(clk),
		.reset(reset),
		.wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb),
		.wb_we_i(wb_we),
		.wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel),
		.wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat),
		.wb_ack_o(wb_ack),
		.standby_sleep(standby),
		.idle_sleep(idle),
		.sources(sources),
		.table_event(tev),
		.table_output_pin_o(pin_o),
		.table_output_pin_oe(pin_oe),
		.peripheral_clock_request(clk_req)
	);
	clm_src_model u_src
	(
		.clk(clk),
		.reset(reset),
		.levels(levels),
		.in2_run(run2),
		.sources(sources)
	);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic xfer(input logic we, input logic [5:0] adr, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_sel <= 4'h1;
		wb_wdat <= {24'h0, d};
		do
		begin
			@(posedge clk);
			k++;
		end
		while (wb_ack !== 1'b1 && k < 50);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (k >= 50)
			err_total++;
	endtask : xfer
	task automatic wr(input logic [5:0] adr, input logic [7:0] d);
		xfer(1'b1, adr, d);
	endtask : wr
	task automatic rd(input logic [5:0] adr, input logic [7:0] exp);
		xfer(1'b0, adr, 8'h00);
		chk(wb_rdat, {24'h0, exp});
	endtask : rd
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask : cyc
	task automatic cfg(input logic [7:0] ca, input logic [7:0] b, input logic [7:0] c,
		input logic [7:0] f, input logic [7:0] g);
		wr(6'h00, 8'h00);
		wr(6'h14, ca);
		wr(6'h18, b);
		wr(6'h1c, c);
		wr(6'h20, f);
		wr(6'h00, g);
	endtask : cfg
	// Only one source is raised, so a wrong select code reads as 0.
	function automatic clm_pkg::clm_sources_t one_src(input logic [3:0] c, input logic i1);
		clm_pkg::clm_sources_t s;
		s = '0;
		case (c)
			4'h3: s.event_line[0] = 1'b1;
			4'h4: s.event_line[1] = 1'b1;
			4'h5: s.pin[0][i1] = 1'b1;
			4'h6: s.comparator_output[0] = 1'b1;
			4'h7: s.timer_b_output[0] = 1'b1;
			4'h8: s.timer_a_output[i1] = 1'b1;
			4'h9: if (i1) s.timer_d_output_b = 1'b1; else s.timer_d_output_a = 1'b1;
			4'ha: if (i1) s.usart_txd = 1'b1; else s.usart_xck = 1'b1;
			4'hb: if (i1) s.spi_mosi = 1'b1; else s.spi_sck = 1'b1;
			4'hc: s.comparator_output[1] = 1'b1;
			4'hd: s.timer_b_output[1] = 1'b1;
			4'he: s.comparator_output[2] = 1'b1;
			default: s = '0;
		endcase
		return s;
	endfunction : one_src
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 12; i++)
			rd(adrs[i], 8'h00);
		for (int i = 1; i < 12; i++)
			wr(adrs[i], wv[i]);
		wr(6'h00, wv[0]);
		for (int i = 1; i < 12; i++)
			wr(adrs[i], 8'h00);
		for (int i = 0; i < 12; i++)
			rd(adrs[i], i >= 10 ? 8'h00 : wv[i]);
		wr(6'h00, 8'h00);
		for (int i = 0; i < 10; i++)
			wr(adrs[i], 8'h00);
		for (int k = 0; k < 24; k++)
		begin
			code = 4'(3 + k % 12);
			in1 = (k >= 12);
			inv = (code == 4'h9) && !in1;
			cfg(8'h09, in1 ? {code, 4'h0} : {4'h0, code}, 8'h00, in1 ? 8'hcc : 8'haa, 8'h01);
			levels <= one_src(code, in1);
			cyc(4);
			chk(tev[0], !inv);
			levels <= '0;
			cyc(4);
			chk({pin_oe[0], pin_o[0], tev[0]}, {1'b1, inv, inv});
		end
		for (int f = 0; f < 3; f++)
		begin
			cfg({2'h0, 2'(f), 4'h1}, 8'h05, 8'h00, 8'haa, 8'h01);
			levels <= '0;
			cyc(4);
			levels <= one_src(4'h5, 1'b0);
			n = 0;
			do
			begin
				@(posedge clk);
				n++;
			end
			while (tev[0] !== 1'b1 && n < 40);
			chk(n >= lo[f] && n <= hi[f], 1'b1);
			levels <= '0;
		end
		cfg(8'h91, 8'h05, 8'h00, 8'haa, 8'h01);
		levels <= one_src(4'h5, 1'b0);
		n = 0;
		repeat (16)
		begin
			@(posedge clk);
			n += (tev[0] === 1'b1);
		end
		chk(n, 1);
		cfg(8'h11, 8'h05, 8'h00, 8'haa, 8'h41);
		cyc(8);
		standby <= 1'b1;
		cyc(4);
		chk({clk_req, tev[0]}, 2'b11);
		wr(6'h00, 8'h01);
		cyc(4);
		chk({clk_req, tev[0]}, 2'b00);
		standby <= 1'b0;
		cfg(8'h01, 8'h05, 8'h00, 8'haa, 8'h41);
		idle <= 1'b1;
		cyc(4);
		chk({clk_req, tev[0]}, 2'b01);
		levels <= '0;
		cyc(4);
		chk(tev[0], 1'b0);
		idle <= 1'b0;
		levels <= one_src(4'h5, 1'b0);
		cfg(8'h51, 8'h05, 8'h05, 8'haa, 8'h01);
		cyc(12);
		chk(tev[0], 1'b0);
		run2 <= 1'b1;
		cyc(12);
		chk(tev[0], 1'b1);
		run2 <= 1'b0;
		for (int s = 0; s < 4; s++)
		begin
			wr(6'h00, 8'h00);
			wr(6'h04, sq[s]);
			wr(6'h24, 8'h01);
			wr(6'h30, s % 2 == 1 ? 8'h00 : 8'hff);
			levels <= one_src(4'h5, 1'b0);
			cfg(8'h01, 8'h05, 8'h00, 8'haa, 8'h01);
			cyc(6);
			chk(tev[0], 1'b1);
			chk({pin_oe[1], pin_o[1], tev[1]}, {1'b0, s % 2 == 0, s % 2 == 0});
			levels <= '0;
			cyc(6);
			chk(tev[0], s % 2 == 1);
		end
		conclude();
	end
	// A hang ends the run as a mismatch.
	initial
	begin
		repeat (30000) @(posedge clk);
		err_total++;
		conclude();
	end
endmodule : tb
`default_nettype wire
